// [common/servo_pkg.sv]
// Package of constants and types for the step/direction closed-loop position servo
// ****************************************************************
// Overview of operation
// [R1] Each rising step edge while enabled moves the commanded position one step in the selected direction.
// [R2] Only the rising edge of step is used and no setting can choose the other edge.
// [R3] The controller changes direction only while step is low, so direction is stable at edges.
// [R4] A polarity setting chooses whether a high direction level means forward or reverse.
// [R5] Enable is sampled at the 6000 per second loop rate, not continuously.
// [R6] The active level of the enable input is configurable.
// [R7] The error output rises while the angle difference exceeds the threshold.
// [R8] The error threshold is a register written through the command port.
// [R9] A signed step count gives the commanded angle via steps per revolution times microsteps.
// [R10] The measured angle comes from a 14-bit encoder with 16384 counts per revolution.
// [R11] Current is Kp times error plus Ki times summed error plus Kd times error change.
// [R12] The law runs in fixed point with a clamped integrator and saturated results.
// [R13] Two position modes are offered: positional PID and simple hybrid PID.
// [R14] In simple hybrid mode current never falls below the hold current while enabled; when disabled it is zero.
// [R15] The loop runs 6000 times per second and advances the motor at most one step each sample.
// [R16] Step, direction and enable are synchronised, and direction is caught at the step edge.
// ****************************************************************
package servo_pkg;
   localparam int unsigned CLK_HZ        = 10000000;
   localparam int unsigned LOOP_HZ       = 6000;
   localparam int unsigned LOOP_DIV      = CLK_HZ / LOOP_HZ;
   localparam int unsigned ENC_BITS      = 14;
   localparam int unsigned ENC_COUNTS    = 16384;
   localparam int unsigned ANGLE_DEG     = 360;
   localparam int unsigned FULL_STEPS    = 200;
   localparam int unsigned MICROSTEPS    = 16;
   // Register offsets
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_THRESH     = 4'h1;
   localparam logic [3:0] REG_KP         = 4'h2;
   localparam logic [3:0] REG_KI         = 4'h3;
   localparam logic [3:0] REG_KD         = 4'h4;
   localparam logic [3:0] REG_HOLD       = 4'h5;
   localparam logic [3:0] REG_IMAX       = 4'h6;
   localparam logic [3:0] REG_STATUS     = 4'h7;
   localparam logic [3:0] REG_IRQ_MASK   = 4'h8;
   localparam logic [3:0] REG_STEPS      = 4'h9;
   localparam logic [3:0] REG_ENCODER    = 4'hA;
   localparam logic [3:0] REG_ERROR      = 4'hB;
   localparam logic [3:0] REG_CURRENT    = 4'hC;
   localparam logic [3:0] REG_MICRO      = 4'hD;
   // Control bit positions
   localparam int unsigned CTRL_DIR_POL  = 0;
   localparam int unsigned CTRL_EN_POL   = 1;
   localparam int unsigned CTRL_MODE     = 2;
   // Interrupt status bit positions
   localparam int unsigned IRQ_ERR_SET   = 0;
   localparam int unsigned IRQ_EN_CHG    = 1;
   localparam int unsigned IRQ_STEP_OVF  = 2;
   // Reset values, gain shift, integrator limit and mode type
   localparam logic [31:0] CTRL_RST      = 32'h0000_0006;
   localparam logic [31:0] THRESH_RST    = 32'h0000_00B6;
   localparam logic [31:0] KP_RST        = 32'h0000_0100;
   localparam logic [31:0] KI_RST        = 32'h0000_0004;
   localparam logic [31:0] KD_RST        = 32'h0000_0200;
   localparam logic [31:0] HOLD_RST      = 32'h0000_0200;
   localparam logic [31:0] IMAX_RST      = 32'h0000_7FFF;
   localparam int unsigned GAIN_SHIFT    = 8;
   localparam int unsigned INT_LIMIT     = 1048576;
   typedef enum logic {POSITIONAL_PID_MODE, SIMPLE_HYBRID_PID_MODE} pid_mode_e;
endpackage

// [logic/step_dir_closed_loop_position.sv]
// Closed-loop step/direction position servo with register port and PID law
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module step_dir_closed_loop_position
   import servo_pkg::*;
#(
   parameter int unsigned STEP_W = 32,
   parameter int unsigned CUR_W  = 16
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              step_in,
   input  wire logic              dir_in,
   input  wire logic              enable_in,
   input  wire logic [ENC_BITS-1:0] encoder_pos,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   output logic                   error_out,
   output logic [CUR_W-1:0]       motor_current,
   output logic                   motor_step,
   output logic                   motor_dir,
   output logic                   motor_enable,
   output logic                   loop_tick,
   output logic                   irq
);
   // ****************************************************************
   // Input edge detection
   // ****************************************************************
   logic step_rise, dir_at_step, enable_sync;
   step_dir_sync u_sync (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .step_in     (step_in),
      .dir_in      (dir_in),
      .enable_in   (enable_in),
      .step_rise   (step_rise),
      .dir_at_step (dir_at_step),
      .enable_sync (enable_sync)
   );

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [31:0] ctrl_q, ctrl_d, thresh_q, thresh_d, kp_q, kp_d, ki_q, ki_d;
   logic [31:0] kd_q, kd_d, hold_q, hold_d, imax_q, imax_d, micro_q, micro_d;
   logic [2:0]  status_q, status_d, mask_q, mask_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0]  events;
   logic signed [STEP_W-1:0] steps_q, steps_d;
   logic signed [31:0] err_q, err_d;
   logic [CUR_W-1:0] cur_q, cur_d;

   // ****************************************************************
   // Loop rate divider
   // ****************************************************************
   logic [15:0] div_q, div_d;
   logic        tick;
   always_comb begin
      tick  = (div_q == 16'(LOOP_DIV - 1));
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
   end
   assign loop_tick = tick; // [R15]

   // ****************************************************************
   // Step counting and enable sampling
   // ****************************************************************
   logic en_q, en_d;
   logic fwd;
   logic ovf;
   always_comb begin
      // Sampled only at the loop rate, so steps can slip in before a change is seen
      en_d = en_q;
      if (tick) begin
         en_d = (enable_sync == ctrl_q[CTRL_EN_POL]); // [R5] [R6]
      end
      fwd     = dir_at_step ^ ctrl_q[CTRL_DIR_POL]; // [R4]
      steps_d = steps_q;
      ovf     = 1'b0;
      if (step_rise && en_q) begin
         if (fwd) begin
            steps_d = steps_q + STEP_W'(1); // [R1] [R9]
            ovf     = (steps_q == {1'b0, {(STEP_W-1){1'b1}}});
         end else begin
            steps_d = steps_q - STEP_W'(1); // [R1] [R9]
            ovf     = (steps_q == {1'b1, {(STEP_W-1){1'b0}}});
         end
      end
   end

   // ****************************************************************
   // Angle and PID law in fixed point
   // ****************************************************************
   // Commanded angle in encoder counts: steps * 16384 / (full steps * microsteps)
   logic signed [63:0] cmd_prod;
   logic signed [31:0] cmd_cnt;
   logic signed [31:0] meas_cnt;
   logic signed [31:0] err_now, abs_err;
   logic signed [31:0] int_q, int_d, prev_q, prev_d;
   logic signed [31:0] int_sum, int_lim;
   logic signed [63:0] u_sum;
   logic [31:0] spr;
   logic [CUR_W-1:0] u_mag, u_lim;
   logic err_flag_q, err_flag_d, dir_q, dir_d, mstep_q, mstep_d;
   always_comb begin
      spr      = 32'(FULL_STEPS) * micro_q;
      cmd_prod = 64'(steps_q) * 64'(ENC_COUNTS); // [R9]
      cmd_cnt  = (spr == 32'h0000_0000) ? 32'sh0 : 32'(cmd_prod / $signed({32'h0, spr}));
      meas_cnt = $signed({18'h0, encoder_pos}); // [R10]
      err_now  = cmd_cnt - meas_cnt;
      abs_err  = err_now[31] ? -err_now : err_now;
      int_d    = int_q;
      prev_d   = prev_q;
      err_d    = err_q;
      cur_d    = cur_q;
      dir_d    = dir_q;
      mstep_d  = 1'b0;
      err_flag_d = err_flag_q;
      // Integrator clamped so windup cannot grow without bound; signed limits
      int_lim  = $signed(32'(INT_LIMIT));
      int_sum  = int_q + err_now;
      u_sum = $signed({32'h0, kp_q}) * 64'(err_now)
            + $signed({32'h0, ki_q}) * 64'(int_q)
            + $signed({32'h0, kd_q}) * 64'(err_now - prev_q); // [R11]
      u_sum = u_sum >>> GAIN_SHIFT; // [R12]
      if (u_sum[63]) begin
         u_mag = (-u_sum > 64'(imax_q)) ? imax_q[CUR_W-1:0] : CUR_W'(-u_sum); // [R12]
      end else begin
         u_mag = (u_sum > 64'(imax_q)) ? imax_q[CUR_W-1:0] : CUR_W'(u_sum); // [R12]
      end
      u_lim = u_mag;
      if (ctrl_q[CTRL_MODE] == SIMPLE_HYBRID_PID_MODE && u_mag < hold_q[CUR_W-1:0]) begin // [R13]
         u_lim = hold_q[CUR_W-1:0]; // [R14]
      end
      if (tick) begin
         if (int_sum > int_lim) begin
            int_d = int_lim; // [R12]
         end else if (int_sum < -int_lim) begin
            int_d = -int_lim; // [R12]
         end else begin
            int_d = int_sum;
         end
         prev_d     = err_now;
         err_d      = err_now;
         err_flag_d = (abs_err > $signed(thresh_q)); // [R7] [R8]
         // Drive follows this sample's enable so current and step agree with motor_enable
         cur_d      = en_d ? u_lim : '0;
         dir_d      = ~u_sum[63];
         mstep_d    = en_d && (u_sum != 64'sd0); // [R15]
      end
      if (!en_q) begin
         int_d = 32'sh0;
      end
   end

   // ****************************************************************
   // Register port and interrupts
   // ****************************************************************
   always_comb begin
      events    = {ovf, tick && (en_d != en_q), tick && err_flag_d && !err_flag_q};
      ctrl_d    = ctrl_q;
      thresh_d  = thresh_q;
      kp_d      = kp_q;
      ki_d      = ki_q;
      kd_d      = kd_q;
      hold_d    = hold_q;
      imax_d    = imax_q;
      micro_d   = micro_q;
      mask_d    = mask_q;
      status_d  = status_q;
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL:     ctrl_d   = reg_wdata;
            REG_THRESH:   thresh_d = reg_wdata; // [R8]
            REG_KP:       kp_d     = reg_wdata; // [R11]
            REG_KI:       ki_d     = reg_wdata; // [R11]
            REG_KD:       kd_d     = reg_wdata; // [R11]
            REG_HOLD:     hold_d   = reg_wdata;
            REG_IMAX:     imax_d   = reg_wdata;
            REG_MICRO:    micro_d  = reg_wdata;
            REG_IRQ_MASK: mask_d   = reg_wdata[2:0];
            REG_STATUS:   status_d = status_q & ~reg_wdata[2:0];
            default:      ;
         endcase
      end
      // Set wins over a clear in the same cycle
      status_d = status_d | events;
      rdata_d  = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL:     rdata_d = ctrl_q;
            REG_THRESH:   rdata_d = thresh_q;
            REG_KP:       rdata_d = kp_q;
            REG_KI:       rdata_d = ki_q;
            REG_KD:       rdata_d = kd_q;
            REG_HOLD:     rdata_d = hold_q;
            REG_IMAX:     rdata_d = imax_q;
            REG_STATUS:   rdata_d = {29'h0, status_q};
            REG_IRQ_MASK: rdata_d = {29'h0, mask_q};
            REG_STEPS:    rdata_d = 32'(steps_q);
            REG_ENCODER:  rdata_d = {18'h0, encoder_pos};
            REG_ERROR:    rdata_d = err_q;
            REG_CURRENT:  rdata_d = 32'(cur_q);
            REG_MICRO:    rdata_d = micro_q;
            default:      rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q      <= 16'h0000;
         en_q       <= 1'b0;
         steps_q    <= '0;
         int_q      <= 32'sh0;
         prev_q     <= 32'sh0;
         err_q      <= 32'sh0;
         cur_q      <= '0;
         dir_q      <= 1'b0;
         mstep_q    <= 1'b0;
         err_flag_q <= 1'b0;
         ctrl_q     <= CTRL_RST;
         thresh_q   <= THRESH_RST;
         kp_q       <= KP_RST;
         ki_q       <= KI_RST;
         kd_q       <= KD_RST;
         hold_q     <= HOLD_RST;
         imax_q     <= IMAX_RST;
         micro_q    <= 32'(MICROSTEPS);
         status_q   <= 3'h0;
         mask_q     <= 3'h0;
         rdata_q    <= 32'h0000_0000;
      end else begin
         div_q      <= div_d;
         en_q       <= en_d;
         steps_q    <= steps_d;
         int_q      <= int_d;
         prev_q     <= prev_d;
         err_q      <= err_d;
         cur_q      <= cur_d;
         dir_q      <= dir_d;
         mstep_q    <= mstep_d;
         err_flag_q <= err_flag_d;
         ctrl_q     <= ctrl_d;
         thresh_q   <= thresh_d;
         kp_q       <= kp_d;
         ki_q       <= ki_d;
         kd_q       <= kd_d;
         hold_q     <= hold_d;
         imax_q     <= imax_d;
         micro_q    <= micro_d;
         status_q   <= status_d;
         mask_q     <= mask_d;
         rdata_q    <= rdata_d;
      end
   end

   assign reg_rdata     = rdata_q;
   assign error_out     = err_flag_q; // [R7]
   assign motor_current = cur_q;
   assign motor_step    = mstep_q; // [R15]
   assign motor_dir     = dir_q;
   assign motor_enable  = en_q;
   assign irq           = |(status_q & mask_q);
endmodule // step_dir_closed_loop_position

// [logic/step_dir_sync.sv]
// Input synchroniser and rising step edge detector
`timescale 1ns/100ps
module step_dir_sync
   import servo_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic step_in,
   input  wire logic dir_in,
   input  wire logic enable_in,
   output logic      step_rise,
   output logic      dir_at_step,
   output logic      enable_sync
);
   logic [2:0] s1_q, s1_d, s2_q, s2_d;
   logic       s3_q, s3_d;
   always_comb begin
      s1_d = {enable_in, dir_in, step_in};
      s2_d = s1_q;
      s3_d = s2_q[0];
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   // Rising edge only; there is deliberately no falling edge option
   assign step_rise   = s2_q[0] & ~s3_q; // [R2] [R16]
   assign dir_at_step = s2_q[1]; // [R16]
   assign enable_sync = s2_q[2];
endmodule // step_dir_sync

// [verif/step_dir_closed_loop_position_properties.sv]
// Port checker for the closed-loop step/direction position servo
`timescale 1ns/100ps
module step_dir_closed_loop_position_properties
   import servo_pkg::*;
#(
   parameter int unsigned STEP_W = 32,
   parameter int unsigned CUR_W  = 16
) (
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire logic                step_in,
   input wire logic                dir_in,
   input wire logic                enable_in,
   input wire logic [ENC_BITS-1:0] encoder_pos,
   input wire logic [3:0]          reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   input wire logic                error_out,
   input wire logic [CUR_W-1:0]    motor_current,
   input wire logic                motor_step,
   input wire logic                motor_dir,
   input wire logic                motor_enable,
   input wire logic                loop_tick,
   input wire logic                irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ****************************************
   // Clocks since the last loop tick
   // ****************************************
   logic [11:0] gap_q, gap_d;
   logic        seen_q, seen_d;
   always_comb begin
      gap_d  = loop_tick ? 12'h000 : gap_q + 12'h001;
      seen_d = seen_q | loop_tick;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q  <= 12'h000;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= gap_d;
         seen_q <= seen_d;
      end
   end
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   rdata_unmapped_a: assert property (reg_rd && reg_addr > REG_MICRO |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   mask_clear_a: assert property (reg_wr && reg_addr == REG_IRQ_MASK && reg_wdata == 32'h0
      |=> !irq) else $error("irq high with mask cleared");
   tick_pulse_a: assert property (loop_tick |=> !loop_tick)
      else $error("loop tick longer than one cycle");
   tick_period_a: assert property (loop_tick && seen_q |-> gap_q == 12'(LOOP_DIV - 1))
      else $error("loop tick period wrong");
   tick_late_a: assert property (seen_q |-> gap_q < 12'(LOOP_DIV))
      else $error("loop tick missing");
   step_at_tick_a: assert property (motor_step |-> $past(loop_tick) && motor_enable)
      else $error("motor step outside a loop sample");
   step_single_a: assert property (motor_step |=> !motor_step)
      else $error("more than one motor step per sample");
   sample_hold_a: assert property (!$past(loop_tick) |-> $stable(motor_enable)
      && $stable(error_out)) else $error("enable or error changed between samples");
   off_current_a: assert property (!motor_enable |-> motor_current == '0)
      else $error("current while disabled");
   cover property (motor_step);
   cover property ($rose(error_out));
   cover property (irq);
endmodule // step_dir_closed_loop_position_properties

bind step_dir_closed_loop_position step_dir_closed_loop_position_properties #(
   .STEP_W(STEP_W), .CUR_W(CUR_W)
) props_u (
   .core_clk(core_clk), .rst_n(rst_n), .step_in(step_in), .dir_in(dir_in),
   .enable_in(enable_in), .encoder_pos(encoder_pos), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .error_out(error_out), .motor_current(motor_current), .motor_step(motor_step),
   .motor_dir(motor_dir), .motor_enable(motor_enable), .loop_tick(loop_tick), .irq(irq)
);

// [verif/step_dir_closed_loop_position_test.sv]
// Self-checking bench for the closed-loop step/direction position servo
`timescale 1ns/100ps
module step_dir_closed_loop_position_test
   import servo_pkg::*;
;
   typedef struct packed {
      logic        wr;
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } row_s;
   logic                core_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                enable_in = 1'b1;
   logic [ENC_BITS-1:0] encoder_pos = '0;
   logic [3:0]          reg_addr = 4'h0;
   logic [31:0]         reg_wdata = 32'h0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic                step_in, dir_in, error_out, motor_step, motor_dir;
   logic                motor_enable, loop_tick, irq;
   logic [31:0]         reg_rdata;
   logic [15:0]         motor_current;
   int                  n_mismatch = 0;
   int                  compares = 0;
   row_s                rows [12] = '{
      '{1'b0, REG_CTRL, 32'h0, CTRL_RST}, '{1'b0, REG_THRESH, 32'h0, THRESH_RST},
      '{1'b0, REG_KP, 32'h0, KP_RST}, '{1'b0, REG_KI, 32'h0, KI_RST},
      '{1'b0, REG_KD, 32'h0, KD_RST}, '{1'b0, REG_HOLD, 32'h0, HOLD_RST},
      '{1'b0, REG_IMAX, 32'h0, IMAX_RST}, '{1'b0, REG_MICRO, 32'h0, 32'h10},
      '{1'b0, REG_STEPS, 32'h0, 32'h0}, '{1'b1, REG_STATUS, 32'h7, 32'h0},
      '{1'b1, REG_THRESH, 32'h20, 32'h20}, '{1'b1, 4'hE, 32'h1234, 32'h0}
   };
   always #50 core_clk = ~core_clk;
   step_dir_source src_u (.core_clk(core_clk), .step_in(step_in), .dir_in(dir_in));
   step_dir_closed_loop_position dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .step_in(step_in), .dir_in(dir_in),
      .enable_in(enable_in), .encoder_pos(encoder_pos), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .error_out(error_out), .motor_current(motor_current), .motor_step(motor_step),
      .motor_dir(motor_dir), .motor_enable(motor_enable), .loop_tick(loop_tick), .irq(irq)
   );
   // ****************************************
   // Bus cycles and comparisons
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, e);
   endtask
   // Registered outputs follow one edge after the tick, so settle past it
   task automatic ticks(input int n);
      repeat (n) begin
         do begin
            @(negedge core_clk);
         end while (loop_tick !== 1'b1);
      end
      repeat (2) @(negedge core_clk);
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr === 1'b1) begin
            wr(rows[i].addr, rows[i].wdata);
         end
         rd(rows[i].addr, rows[i].exp);
      end
      ticks(2);
      chk(motor_enable, 1'b1);
      @(posedge core_clk);
      encoder_pos <= 14'h0100;
      ticks(2);
      chk(error_out, 1'b1);
      chk(motor_dir, 1'b0);
      rd(REG_ENCODER, 32'h100);
      wr(REG_IRQ_MASK, 32'h1);
      @(negedge core_clk);
      chk(irq, 1'b1);
      wr(REG_STATUS, 32'h1);
      @(negedge core_clk);
      chk(irq, 1'b0);
      wr(REG_THRESH, 32'h200);
      ticks(2);
      chk(error_out, 1'b0);
      wr(REG_THRESH, THRESH_RST);
      src_u.burst(50, 1'b1);
      src_u.burst(3, 1'b0);
      rd(REG_STEPS, 32'h2F);
      ticks(2);
      chk(error_out, 1'b0);
      chk(motor_current >= 16'h0200, 1'b1);
      wr(REG_HOLD, 32'h300);
      ticks(2);
      chk(motor_current >= 16'h0300, 1'b1);
      wr(REG_CTRL, 32'h7);
      src_u.burst(2, 1'b1);
      rd(REG_STEPS, 32'h2D);
      @(posedge core_clk);
      enable_in <= 1'b0;
      ticks(2);
      chk(motor_enable, 1'b0);
      chk(motor_current, 32'h0);
      src_u.burst(3, 1'b1);
      rd(REG_STEPS, 32'h2D);
      wr(REG_CTRL, 32'h5);
      ticks(2);
      chk(motor_enable, 1'b1);
      src_u.burst(1, 1'b1);
      rd(REG_STEPS, 32'h2C);
      // Positional mode has no hold floor, so a small current cap must win
      wr(REG_IMAX, 32'h10);
      wr(REG_CTRL, 32'h1);
      ticks(2);
      chk(motor_current <= 16'h0010, 1'b1);
      wr(REG_IRQ_MASK, 32'h2);
      @(negedge core_clk);
      chk(irq, 1'b1);
      wr(REG_IRQ_MASK, 32'h0);
      @(negedge core_clk);
      chk(irq, 1'b0);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(REG_STEPS, 32'h0);
      rd(REG_CTRL, CTRL_RST);
      finish_test;
   end
endmodule // step_dir_closed_loop_position_test

// [verif/step_dir_source.sv]
// Behavioural step/direction motion controller
`timescale 1ns/100ps
module step_dir_source (
   input  wire logic core_clk,
   output logic      step_in,
   output logic      dir_in
);
   initial begin
      step_in = 1'b0;
      dir_in  = 1'b0;
   end
   // Direction moves only with step low, well ahead of the next rising edge
   task automatic burst(input int n, input logic dir);
      repeat (3) @(posedge core_clk);
      dir_in <= dir;
      for (int i = 0; i < n; i++) begin
         repeat (3) @(posedge core_clk);
         step_in <= 1'b1;
         repeat (3) @(posedge core_clk);
         step_in <= 1'b0;
      end
      repeat (6) @(posedge core_clk);
   endtask
endmodule // step_dir_source
